// [shared/supervision_timer_pkg.sv]
/*
 * constants for the supervision timer: register indices, field positions,
 * reset values and counts.
 * assumes a 32-bit axi4-lite register bus and a sampled ~1 khz watchdog clock.
 */
// Functional notes
// - counting continues in every sleep mode
// - control write syncs over; pending flag meanwhile
// - kick takes two to three ticks
// - kick during kick sync is dropped
// - key then protected write within four instructions
// - unguarded protected write accepted, value kept
// - window, timeout, lock guarded; pending flag not
// - bits 7:4 closed span, nonzero enables window
// - bits 3:0 enable, timeout or open span
// - codes 1..11 give 8 to 8k ticks
// - lock makes control register read-only
// - software sets lock; clears only in debug
// - nonzero timeout after boot sets lock
// - status resets to zero; pending bit0, lock bit7
// - control resets from boot configuration fuse
// - normal mode: kick restarts, expiry resets system
// - window mode: early kick or late kick resets
// - first closed span starts after first kick
package supervision_timer_pkg;
    localparam logic [5:0] CONTROL_A_INDEX = 6'h00;
    localparam logic [5:0] STATUS_INDEX = 6'h01;
    localparam logic [5:0] CHANGE_GUARD_INDEX = 6'h02;
    localparam int PERIOD_LSB = 0;
    localparam int WINDOW_LSB = 4;
    localparam int PENDING_BIT = 0;
    localparam int LOCK_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] CODE_MAX = 4'hB;
    localparam logic [3:0] CODE_SHIFT = 4'h2;
    localparam logic [13:0] SPAN_MAX = 14'h2000;
    localparam logic [1:0] SYNC_TICKS = 2'h3;
    localparam logic [2:0] GUARD_INSTRS = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_CLOSED, WD_OPEN} wd_state_t;
endpackage : supervision_timer_pkg

// [shared/tick_sync_if.sv]
/*
 * carrier between the timer top and its tick-domain synchroniser.
 * assumes one clock; tick is a one-cycle pulse per rising watchdog clock edge.
 */
`timescale 1ns/1ps
interface tick_sync_if;
    logic tick;
    logic start;
    logic busy;
    logic done;
    modport owner (output tick, output start, input busy, input done);
    modport syncer (input tick, input start, output busy, output done);
endinterface : tick_sync_if

// [src/tick_sync.sv]
/*
 * carries a request across a fixed number of watchdog ticks.
 * assumes start is a one-cycle pulse and tick a one-cycle pulse.
 */
`timescale 1ns/1ps
module tick_sync (
    input wire logic clk_sys,
    input wire logic resetn,
    tick_sync_if.syncer port
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [1:0] cnt;
    } sync_state_t;
    sync_state_t q;
    sync_state_t d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (port.start && !q.busy) begin
            // a start while busy is dropped, not queued
            d.busy = 1'b1;
            d.cnt = 2'h0;
        end else if (q.busy && port.tick) begin
            // first tick may come at once, so 2 to 3 tick periods in all
            if (q.cnt == supervision_timer_pkg::SYNC_TICKS - 2'h1) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end else begin
                d.cnt = q.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign port.busy = q.busy;
    assign port.done = q.done;
endmodule : tick_sync

// [src/supervision_timer.sv]
/*
 * windowed supervision timer with guarded configuration and lock,
 * reached over axi4-lite.
 * assumes wd_clk is a slow level sampled on clk_sys, kick_instr and
 * instr_step are one-cycle pulses from the cpu core.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module supervision_timer #(
    parameter logic [7:0] IO_UNLOCK_KEY = 8'h5A // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic wd_clk,
    input wire logic kick_instr,
    input wire logic instr_step,
    input wire logic debug_mode,
    input wire logic cpu_halted,
    input wire logic boot_done,
    input wire logic [7:0] boot_cfg_fuse,
    output logic sys_reset_req
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [5:0] aw_index;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic fuse_loaded;
        logic boot_prev;
        logic [7:0] control_a;
        logic [7:0] active_ctrl;
        logic lock;
        logic [2:0] guard_cnt;
        logic ctrl_start;
        logic wd_prev;
        supervision_timer_pkg::wd_state_t wd_state;
        logic [13:0] count;
        logic reset_req;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    tick_sync_if ctrl_sync ();
    tick_sync_if kick_sync ();

    tick_sync ctrl_xfer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .port(ctrl_sync.syncer)
    );

    tick_sync kick_xfer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .port(kick_sync.syncer)
    );

    // wd_clk is sampled, so one tick per rising edge of it
    logic tick;
    // held off until the fuse is in, so a high wd_clk at reset release is no tick
    assign tick = wd_clk && !q.wd_prev && q.fuse_loaded;
    assign ctrl_sync.tick = tick;
    assign kick_sync.tick = tick;
    assign ctrl_sync.start = q.ctrl_start;
    assign kick_sync.start = kick_instr;

    function automatic logic [13:0] span_of(input logic [3:0] code);
        if (code == 4'h0) begin
            span_of = 14'h0000;
        end else if (code > supervision_timer_pkg::CODE_MAX) begin
            // reserved codes behave as the longest span
            span_of = supervision_timer_pkg::SPAN_MAX;
        end else begin
            span_of = 14'h0001 << (code + supervision_timer_pkg::CODE_SHIFT);
        end
    endfunction : span_of

    logic pending;
    logic guard_open;
    logic [3:0] act_period;
    logic [3:0] act_window;
    logic [13:0] period_span;
    logic [13:0] window_span;
    logic [5:0] rd_index;

    assign pending = q.ctrl_start || ctrl_sync.busy;
    assign guard_open = q.guard_cnt != 3'h0;
    assign act_period = q.active_ctrl[supervision_timer_pkg::PERIOD_LSB +: 4];
    assign act_window = q.active_ctrl[supervision_timer_pkg::WINDOW_LSB +: 4];
    assign period_span = span_of(act_period);
    assign window_span = span_of(act_window);
    assign rd_index = araddr[7:2];

    always_comb begin
        d = q;
        d.ctrl_start = 1'b0;
        d.wd_prev = wd_clk;
        // a boot_done held through reset still gives one edge once control holds the fuse
        d.boot_prev = boot_done && q.fuse_loaded;

        // boot: control takes the fuse once after reset release
        if (!q.fuse_loaded) begin
            d.fuse_loaded = 1'b1;
            d.control_a = boot_cfg_fuse;
            d.active_ctrl = boot_cfg_fuse;
        end

        // guard window counts down per executed instruction
        if (instr_step && guard_open) begin
            d.guard_cnt = q.guard_cnt - 3'h1;
        end

        // write address and data may arrive in either order
        if (awvalid && q.awready) begin
            d.aw_held = 1'b1;
            d.aw_index = awaddr[7:2];
        end
        if (wvalid && q.wready) begin
            d.w_held = 1'b1;
            d.w_byte = wdata[7:0];
            d.w_lane0 = wstrb[0];
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_held && q.w_held && !q.bvalid) begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = supervision_timer_pkg::RESP_OKAY;
            case (q.aw_index)
                supervision_timer_pkg::CONTROL_A_INDEX: begin
                    // refused writes still answer okay, value kept
                    if (q.w_lane0 && guard_open && !q.lock && !pending) begin
                        d.control_a = q.w_byte;
                        d.ctrl_start = 1'b1;
                        d.guard_cnt = 3'h0;
                    end
                end
                supervision_timer_pkg::STATUS_INDEX: begin
                    // pending bit is read-only, so it needs no key
                    if (q.w_lane0 && guard_open) begin
                        if (q.w_byte[supervision_timer_pkg::LOCK_BIT]) begin
                            d.lock = 1'b1;
                        end else if (debug_mode) begin
                            d.lock = 1'b0;
                        end
                        d.guard_cnt = 3'h0;
                    end
                end
                supervision_timer_pkg::CHANGE_GUARD_INDEX: begin
                    if (q.w_lane0 && q.w_byte == IO_UNLOCK_KEY) begin
                        d.guard_cnt = supervision_timer_pkg::GUARD_INSTRS;
                    end
                end
                default: begin
                    d.bresp = supervision_timer_pkg::RESP_SLVERR;
                end
            endcase
        end

        // hardware set of the lock wins over a debug clear
        if (boot_done && !q.boot_prev && q.control_a[supervision_timer_pkg::PERIOD_LSB +: 4] != 4'h0) begin
            d.lock = 1'b1;
        end

        d.awready = !d.aw_held && !d.bvalid;
        d.wready = !d.w_held && !d.bvalid;

        // read channel
        if (arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = supervision_timer_pkg::RESP_OKAY;
            d.rdata = 32'h0000_0000;
            case (rd_index)
                supervision_timer_pkg::CONTROL_A_INDEX: begin
                    d.rdata[7:0] = q.control_a;
                end
                supervision_timer_pkg::STATUS_INDEX: begin
                    d.rdata[supervision_timer_pkg::LOCK_BIT] = q.lock;
                    d.rdata[supervision_timer_pkg::PENDING_BIT] = pending;
                end
                supervision_timer_pkg::CHANGE_GUARD_INDEX: begin
                    d.rdata[2:0] = q.guard_cnt;
                end
                default: begin
                    d.rresp = supervision_timer_pkg::RESP_SLVERR;
                end
            endcase
        end else if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        d.arready = !d.rvalid;

        // timer side; nothing here looks at sleep, so it runs on in every sleep mode
        if (ctrl_sync.done) begin
            // new setting: window mode waits for its first kick
            d.active_ctrl = q.control_a;
            d.count = 14'h0000;
            d.wd_state = (q.control_a[supervision_timer_pkg::PERIOD_LSB +: 4] != 4'h0) ?
                supervision_timer_pkg::WD_RUN : supervision_timer_pkg::WD_OFF;
        end else if (cpu_halted) begin
            // halt clears the count; restart behaves as normal mode until a kick
            d.count = 14'h0000;
            d.wd_state = (act_period != 4'h0) ? supervision_timer_pkg::WD_RUN : supervision_timer_pkg::WD_OFF;
        end else begin
            case (q.wd_state)
                supervision_timer_pkg::WD_OFF: begin
                    d.count = 14'h0000;
                    if (act_period != 4'h0) begin
                        d.wd_state = supervision_timer_pkg::WD_RUN;
                    end
                end
                supervision_timer_pkg::WD_RUN: begin
                    if (kick_sync.done) begin
                        d.count = 14'h0000;
                        if (act_window != 4'h0) begin
                            d.wd_state = supervision_timer_pkg::WD_CLOSED;
                        end
                    end else if (tick) begin
                        if (q.count + 14'h0001 >= period_span) begin
                            d.reset_req = 1'b1;
                        end else begin
                            d.count = q.count + 14'h0001;
                        end
                    end
                end
                supervision_timer_pkg::WD_CLOSED: begin
                    if (kick_sync.done) begin
                        d.reset_req = 1'b1;
                    end else if (tick) begin
                        if (q.count + 14'h0001 >= window_span) begin
                            d.count = 14'h0000;
                            d.wd_state = supervision_timer_pkg::WD_OPEN;
                        end else begin
                            d.count = q.count + 14'h0001;
                        end
                    end
                end
                supervision_timer_pkg::WD_OPEN: begin
                    if (kick_sync.done) begin
                        d.count = 14'h0000;
                        d.wd_state = supervision_timer_pkg::WD_CLOSED;
                    end else if (tick) begin
                        if (q.count + 14'h0001 >= period_span) begin
                            d.reset_req = 1'b1;
                        end else begin
                            d.count = q.count + 14'h0001;
                        end
                    end
                end
                default: begin
                    d.wd_state = supervision_timer_pkg::WD_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.wd_state <= supervision_timer_pkg::WD_OFF;
        end else begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign sys_reset_req = q.reset_req;
endmodule : supervision_timer

// [bench/supervision_timer_monitor.sv]
/* port assertions for the supervision timer.
   assumes a bind onto the top module and one clock. */
`timescale 1ns/1ps
module supervision_timer_monitor (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic sys_reset_req
);
    logic [5:0] rd_idx;
    // read answers come after the take, so keep the index it was taken with
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_idx <= 6'h00;
        end else if (arvalid && arready) begin
            rd_idx <= araddr[7:2];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
    property p_b_answer;
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    property p_r_answer;
        arvalid && arready |=> rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_unmapped;
        rvalid && rd_idx > 6'h02 |-> rresp == 2'h2 && rdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_status_bits;
        rvalid && rd_idx == 6'h01 |-> rdata[6:1] == 6'h00 && rdata[31:8] == 24'h000000;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status spare bits set");
    property p_req_sticky;
        sys_reset_req |=> sys_reset_req;
    endproperty
    a_req_sticky: assert property (p_req_sticky) else $error("reset request dropped");
    property p_ready_gap;
        bvalid || rvalid |-> !(bvalid && (awready || wready)) && !(rvalid && arready);
    endproperty
    a_ready_gap: assert property (p_ready_gap) else $error("ready while answer pending");
    c_unmapped: cover property (bvalid && bresp == 2'h2);
    c_sysreset: cover property ($rose(sys_reset_req));
    c_locked: cover property (rvalid && rd_idx == 6'h01 && rdata[7]);
endmodule : supervision_timer_monitor

bind supervision_timer supervision_timer_monitor mon_i (.clk_sys, .resetn, .awvalid,
    .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .sys_reset_req);

// [bench/cpu_core_model.sv]
/* cpu core model: axi4-lite master, kick and instruction pulses.
   assumes a slave that answers each request in its own time. */
`timescale 1ns/1ps
module cpu_core_model #(
    parameter logic [7:0] KEY = 8'h00
) (
    input wire logic clk_sys,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    output logic [7:0] awaddr,
    output logic awvalid,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    output logic rready,
    output logic kick_instr,
    output logic instr_step
);
    localparam logic [7:0] GUARD = {supervision_timer_pkg::CHANGE_GUARD_INDEX, 2'h0};
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, kick_instr, instr_step} = 7'h00;
        {awaddr, araddr} = 16'h0000;
        wdata = 32'h00000000;
        wstrb = 4'hF;
    end
    task wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {24'h000000, v};
        {awvalid, wvalid, bready} <= 3'h7;
        while (pa || pw) begin
            @(posedge clk_sys);
            if (pa && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a; // released lines do not keep their value
                pa = 1'b0;
            end
            if (pw && wready) begin
                wvalid <= 1'b0;
                wdata <= ~{24'h000000, v};
                pw = 1'b0;
            end
        end
        do @(posedge clk_sys); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge clk_sys); while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task step(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            instr_step <= 1'b1;
            @(posedge clk_sys);
            instr_step <= 1'b0;
        end
    endtask : step
    // key first, then n other instructions before the guarded write
    task gw(input logic [7:0] a, input logic [7:0] v, input int n, output logic [1:0] r);
        wr(GUARD, KEY, r);
        step(n);
        wr(a, v, r);
    endtask : gw
    task kick();
        @(posedge clk_sys);
        kick_instr <= 1'b1;
        @(posedge clk_sys);
        kick_instr <= 1'b0;
    endtask : kick
endmodule : cpu_core_model

// [bench/supervision_timer_tb.sv]
/* self-checking bench for the supervision timer.
   assumes the cpu core model for bus cycles, kicks and steps. */
`timescale 1ns/1ps
module supervision_timer_tb;
    localparam logic [7:0] KEY = 8'h3C; // arbitrary unlock value
    localparam logic [7:0] A_CTL = {supervision_timer_pkg::CONTROL_A_INDEX, 2'h0};
    localparam logic [7:0] A_ST = {supervision_timer_pkg::STATUS_INDEX, 2'h0};
    localparam logic [7:0] A_BAD = 8'h0C;
    logic [7:0] awaddr, araddr, boot_cfg_fuse = 8'h00;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic kick_instr, instr_step, sys_reset_req, wd_clk = 1'b0;
    logic clk_sys = 1'b0, resetn = 1'b0, debug_mode = 1'b0, cpu_halted = 1'b0, boot_done = 1'b0;
    int failures = 0, tests_run = 0;
    supervision_timer #(.IO_UNLOCK_KEY(KEY)) supervision_timer_i (.clk_sys, .resetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .wd_clk, .kick_instr, .instr_step,
        .debug_mode, .cpu_halted, .boot_done, .boot_cfg_fuse, .sys_reset_req);
    cpu_core_model #(.KEY(KEY)) cpu (.clk_sys, .awready, .wready, .bvalid, .bresp, .arready,
        .rvalid, .rdata, .rresp, .awaddr, .awvalid, .wdata, .wstrb, .wvalid, .bready, .araddr,
        .arvalid, .rready, .kick_instr, .instr_step);
    always #4 clk_sys = ~clk_sys;
    // watchdog clock sped up to 8 system cycles so spans stay short
    always begin
        repeat (4) @(posedge clk_sys);
        wd_clk <= ~wd_clk;
    end
    task idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
    task rst(input logic [7:0] f);
        @(posedge clk_sys);
        boot_cfg_fuse <= f;
        resetn <= 1'b0;
        idle(16);
        resetn <= 1'b1;
        idle(2);
    endtask : rst
    task end_of_test();
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task peek(input logic [7:0] a, input logic [31:0] e, input string n);
        cpu.rd(a, d, r);
        chk(n, e, d);
    endtask : peek
    initial begin
        idle(20000);
        failures++;
        end_of_test();
    end
    initial begin
        rst(8'h00);
        peek(A_ST, 32'h00, "status");
        peek(A_CTL, 32'h00, "control");
        cpu.wr(A_CTL, 8'h01, r);
        chk("bresp", 32'h0, 32'(r));
        peek(A_CTL, 32'h00, "control");
        cpu.wr(A_ST, 8'h80, r);
        peek(A_ST, 32'h00, "status");
        cpu.gw(A_CTL, 8'h01, 6, r);
        peek(A_CTL, 32'h00, "control");
        cpu.gw(A_CTL, 8'h01, 3, r);
        peek(A_CTL, 32'h01, "control");
        peek(A_ST, 32'h01, "status");
        idle(40);
        peek(A_ST, 32'h00, "status");
        repeat (6) begin
            cpu.kick();
            idle(30);
        end
        chk("reset request", 32'h0, 32'(sys_reset_req));
        idle(80);
        chk("reset request", 32'h1, 32'(sys_reset_req));
        rst(8'h00);
        cpu.wr(A_BAD, 8'h00, r);
        chk("bresp", 32'h2, 32'(r));
        cpu.rd(A_BAD, d, r);
        chk("rresp", 32'h2, 32'(r));
        cpu.gw(A_ST, 8'h80, 0, r);
        peek(A_ST, 32'h80, "status");
        cpu.gw(A_CTL, 8'h12, 0, r);
        peek(A_CTL, 32'h00, "control");
        cpu.gw(A_ST, 8'h00, 0, r);
        peek(A_ST, 32'h80, "status");
        debug_mode <= 1'b1;
        cpu.gw(A_ST, 8'h00, 0, r);
        peek(A_ST, 32'h00, "status");
        debug_mode <= 1'b0;
        rst(8'h01);
        boot_done <= 1'b1;
        idle(4);
        peek(A_CTL, 32'h01, "control");
        peek(A_ST, 32'h80, "status");
        boot_done <= 1'b0;
        rst(8'h00);
        cpu.gw(A_CTL, 8'h11, 0, r);
        idle(32);
        cpu.kick();
        cpu.kick();
        idle(40);
        chk("reset request", 32'h0, 32'(sys_reset_req));
        // halt clears the count; the first kick after it must not meet a closed span
        cpu_halted <= 1'b1;
        idle(4);
        cpu_halted <= 1'b0;
        cpu.kick();
        idle(40);
        chk("reset request", 32'h0, 32'(sys_reset_req));
        cpu.kick();
        idle(40);
        chk("reset request", 32'h1, 32'(sys_reset_req));
        end_of_test();
    end
endmodule : supervision_timer_tb
